/* hw/adc_seq_pkg.sv */
// constants shared by the converter sequencer and its bus controller
// assumes a 250 MHz system clock on both ends of the serial link
package adc_seq_pkg;
	localparam int CLK_NS       = 4;
	localparam int ACQ_NS       = 1250;
	localparam int CONV_NS      = 3200;
	localparam int AUTO_CONV_NS = 3600;
	localparam int AUTO_PER_NS  = 50000;
	localparam int QTR_NS       = 625;
	// least times round up to whole cycles
	localparam int CMD_CYC  = (ACQ_NS + CONV_NS + CLK_NS - 1) / CLK_NS;
	localparam int AUTO_CYC = (AUTO_CONV_NS + CLK_NS - 1) / CLK_NS;
	localparam int AUTO_PER_CYC = (AUTO_PER_NS + CLK_NS - 1) / CLK_NS;
	localparam int QTR_CYC  = (QTR_NS + CLK_NS - 1) / CLK_NS;

	// register pointer values inside the converter
	localparam logic [7:0] PTR_CMD   = 8'h00;
	localparam logic [7:0] PTR_VOLT  = 8'h01;
	localparam logic [7:0] PTR_TEMP  = 8'h02;
	localparam logic [7:0] PTR_ALERT = 8'h1F;
	// command word fields
	localparam int CMD_AUTO_BIT = 0;
	localparam int CMD_POL_BIT  = 3;
	localparam int CMD_TEMP_BIT = 7;
	localparam int CMD_CH_TOP   = 15;
	localparam int NCH          = 9;
	localparam logic [3:0] TEMP_ID = 4'h8;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	// arbitrary bus address of the converter
	localparam logic [6:0] SLAVE_ADDR = 7'h2F;

	// controller registers, byte addresses on the system bus
	localparam logic [7:0] H_CTRL  = 8'h00;
	localparam logic [7:0] H_STAT  = 8'h04;
	localparam logic [7:0] H_RDATA = 8'h08;
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_PTR   = 2'b01,
		OP_READ  = 2'b10
	} op_t;

	// channel mask: top command bit is input zero, temp last
	function automatic logic [NCH-1:0] sel_mask(input logic [15:0] c);
		logic [NCH-1:0] m;
		m = '0;
		for (int i = 0; i < 8; i++) m[i] = c[CMD_CH_TOP - i];
		m[8] = c[CMD_TEMP_BIT];
		return m;
	endfunction : sel_mask

	// lowest selected channel at or above from, wrapping round
	function automatic logic [3:0] next_sel(input logic [NCH-1:0] m,
		input logic [3:0] from);
		logic [3:0] r;
		r = '0;
		for (int i = NCH - 1; i >= 0; i--) if (m[i]) r = 4'(i);
		for (int i = NCH - 1; i >= 0; i--)
			if (m[i] && 4'(i) >= from) r = 4'(i);
		return r;
	endfunction : next_sel
endpackage : adc_seq_pkg

/* hw/adc_link_if.sv */
// two-wire link between bus controller and converter
// open-drain lines are resolved here from the enables
`timescale 1ns/1ps
interface adc_link_if;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic alert;
	wire  scl;
	wire  sda;
	// a line is low while any enabled driver pulls it low
	assign scl = ~(scl_h_oe & ~scl_h_o);
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
	modport host (output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe,
		input scl, sda, alert);
	modport dev (output sda_d_o, sda_d_oe, alert, input scl, sda);
endinterface : adc_link_if

/* hw/adc_seq_dev.sv */
// converter end: serial slave, command and autocycle sequencing
// assumes samples arrive on SAMPLE_DATA by the end of each conversion
//
// Notes on behaviour
// - start and idle in partial power-down
// - addressing the device wakes it
// - command write selects command mode, arms sequence
// - master readdresses for read of result
// - convert during channel bits, next on read
// - command conversion lasts about 4.45 us
// - command mode walks selected channels upward
// - master nacks last byte then stops
// - stop halts conversion, keeps command word
// - resumed reads restart at first channel
// - result is two bytes, id then low
// - after last channel wrap to first
// - upper command byte selects channels
// - command write aborts running sequence
// - autocycle converts about every 50 us
// - autocycle conversion lasts about 3.6 us
// - autocycle keeps bus free, latest result
// - autocycle off at reset, bit zero enables
// - autocycle loops lowest to highest
// - compare limits, raise alert per polarity
// - master clears autocycle before command conversion
// - stop keeps autocycle running
// - pointer stays valid across reads
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module adc_seq_dev #(
	parameter int          AUTO_PER_CYC = adc_seq_pkg::AUTO_PER_CYC,
	parameter logic [6:0]  DEV_ADDR     = adc_seq_pkg::SLAVE_ADDR,
	parameter logic [11:0] LIMIT_HIGH   = 12'hFFF,
	parameter logic [11:0] LIMIT_LOW    = 12'h000
) (
	adc_link_if.dev           LINK,
	input  wire logic         SYS_CLK,
	input  wire logic         RST_N,
	input  wire logic [11:0]  SAMPLE_DATA,
	output logic      [3:0]   SAMPLE_CHAN,
	output logic              SAMPLE_REQ,
	output logic              CONV_BUSY,
	output logic              PART_PD,
	output logic              AUTO_ON
);
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_RX    = 3'b001,
		S_RXACK = 3'b010,
		S_TX    = 3'b011,
		S_TXACK = 3'b100
	} sl_t;

	sl_t         state_reg;
	logic [2:0]  scl_sy, sda_sy;
	logic [3:0]  cnt_reg;
	logic [7:0]  sh_reg, ptr_reg, hi_reg;
	logic [1:0]  idx_reg;
	logic        rd_reg, ack_reg, lo_reg, mack_reg;
	logic [15:0] cmd_reg;
	logic        pd_reg, busy_reg, req_reg;
	logic [3:0]  from_reg, chan_reg, cchan_reg;
	logic [12:0] cyc_reg;
	logic [11:0] res_reg, temp_reg;
	logic [8:0]  alst_reg, alst_next;
	logic [15:0] per_reg;

	// two flip-flops per pin, third stage only for edges
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_sy <= 3'h7;
			sda_sy <= 3'h7;
		end else begin
			scl_sy <= {scl_sy[1:0], LINK.scl};
			sda_sy <= {sda_sy[1:0], LINK.sda};
		end
	end

	wire scl_now = scl_sy[1];
	wire sda_now = sda_sy[1];
	wire start_ev = scl_now & scl_sy[2] & sda_sy[2] & ~sda_now;
	wire stop_ev  = scl_now & scl_sy[2] & ~sda_sy[2] & sda_now;
	wire rise = scl_now & ~scl_sy[2];
	wire fall = ~scl_now & scl_sy[2];

	// received byte and its effect
	wire byte_in  = fall & (state_reg == S_RX) & (cnt_reg == 4'h8);
	wire addr_hit = sh_reg[7:1] == DEV_ADDR;
	wire wr_lo    = byte_in & (idx_reg == 2'h3);
	wire wr_cmd   = wr_lo & (ptr_reg == adc_seq_pkg::PTR_CMD);
	wire wr_alert = wr_lo & (ptr_reg == adc_seq_pkg::PTR_ALERT);
	wire wake     = byte_in & (idx_reg == 2'h0) & addr_hit;

	// command word decode
	wire [8:0] mask = adc_seq_pkg::sel_mask(cmd_reg);
	wire auto_en = cmd_reg[adc_seq_pkg::CMD_AUTO_BIT];
	wire pol     = cmd_reg[adc_seq_pkg::CMD_POL_BIT];

	// a result word begins on the first byte of each read pair
	wire word_start = (fall & (state_reg == S_RXACK) & (idx_reg == 2'h0)
		& rd_reg) | (fall & (state_reg == S_TXACK) & mack_reg & lo_reg);
	// conversion for the next channel starts as the read begins
	wire cmd_start = word_start & ~auto_en & (|mask) & ~wr_cmd
		& (ptr_reg == adc_seq_pkg::PTR_VOLT);
	wire tick = per_reg == 16'h0001;
	wire auto_start = auto_en & tick & ~busy_reg & (|mask);
	wire conv_go = cmd_start | auto_start;
	wire [3:0] go_chan = adc_seq_pkg::next_sel(mask, from_reg);
	wire done = busy_reg & (cyc_reg == 13'h0001);
	wire halt = wr_cmd | (stop_ev & ~auto_en);
	wire viol = (SAMPLE_DATA > LIMIT_HIGH) | (SAMPLE_DATA < LIMIT_LOW);

	// reply word by pointer; result word is id then data
	wire [15:0] word =
		(ptr_reg == adc_seq_pkg::PTR_CMD)  ? cmd_reg :
		(ptr_reg == adc_seq_pkg::PTR_VOLT) ? {cchan_reg, res_reg} :
		(ptr_reg == adc_seq_pkg::PTR_TEMP) ?
			{adc_seq_pkg::TEMP_ID, temp_reg} :
		(ptr_reg == adc_seq_pkg::PTR_ALERT) ? {7'h00, alst_reg} :
		16'h0000;
	wire [7:0] tx_byte = lo_reg ? word[7:0] : word[15:8];
	wire       tx_bit  = tx_byte[3'(4'h7 - cnt_reg)];

	// pull sda low for our ack and for zero data bits
	assign LINK.sda_d_o  = 1'b0;
	assign LINK.sda_d_oe = ((state_reg == S_RXACK) & ack_reg)
		| ((state_reg == S_TX) & ~tx_bit);

	// bus slave framing
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			idx_reg   <= 2'h0;
			rd_reg    <= 1'b0;
			ack_reg   <= 1'b0;
			lo_reg    <= 1'b0;
			mack_reg  <= 1'b0;
		end else if (stop_ev) begin
			state_reg <= S_IDLE;
		end else if (start_ev) begin
			state_reg <= S_RX;
			cnt_reg   <= 4'h0;
			idx_reg   <= 2'h0;
		end else begin
			unique case (state_reg)
				S_IDLE: ;
				S_RX: begin
					if (rise) begin
						sh_reg  <= {sh_reg[6:0], sda_now};
						cnt_reg <= cnt_reg + 4'h1;
					end
					if (byte_in) begin
						cnt_reg <= 4'h0;
						ack_reg <= 1'b1;
						if (idx_reg == 2'h0) rd_reg <= sh_reg[0];
						if (idx_reg == 2'h0 && !addr_hit)
							state_reg <= S_IDLE;
						else
							state_reg <= S_RXACK;
					end
				end
				S_RXACK: if (fall) begin
					ack_reg <= 1'b0;
					if (idx_reg == 2'h0 && rd_reg) begin
						state_reg <= S_TX;
						lo_reg    <= 1'b0;
					end else begin
						state_reg <= S_RX;
						// after the low byte a new pointer follows
						idx_reg <= (idx_reg == 2'h3) ? 2'h1 : idx_reg + 2'h1;
					end
				end
				S_TX: if (fall) begin
					if (cnt_reg == 4'h7) begin
						cnt_reg   <= 4'h0;
						state_reg <= S_TXACK;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				S_TXACK: begin
					if (rise) mack_reg <= ~sda_now;
					// a nack ends our transmission until the stop
					if (fall) begin
						state_reg <= mack_reg ? S_TX : S_IDLE;
						lo_reg    <= ~lo_reg;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// pointer and register writes; pointer persists across reads
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ptr_reg <= adc_seq_pkg::PTR_CMD;
			hi_reg  <= 8'h00;
			cmd_reg <= adc_seq_pkg::CMD_RESET;
		end else if (byte_in) begin
			if (idx_reg == 2'h1) ptr_reg <= sh_reg;
			if (idx_reg == 2'h2) hi_reg <= sh_reg;
			if (wr_cmd) cmd_reg <= {hi_reg, sh_reg};
		end
	end

	// power state: asleep until addressed or in autocycle, back on a stop outside autocycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			pd_reg <= 1'b1;
		else if (wake)
			pd_reg <= 1'b0;
		else if (stop_ev && !auto_en)
			pd_reg <= 1'b1;
		else if (auto_en)
			pd_reg <= 1'b0;
	end

	// background interval timer, runs only in autocycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			per_reg <= 16'h0000;
		else if (!auto_en || tick)
			per_reg <= 16'(AUTO_PER_CYC);
		else
			per_reg <= per_reg - 16'h0001;
	end

	// conversion engine and channel stepping
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			busy_reg  <= 1'b0;
			req_reg   <= 1'b0;
			cyc_reg   <= 13'h0000;
			from_reg  <= 4'h0;
			chan_reg  <= 4'h0;
			cchan_reg <= 4'h0;
			res_reg   <= 12'h000;
			temp_reg  <= 12'h000;
		end else begin
			req_reg <= conv_go & ~halt;
			if (halt) begin
				// a restart always begins at the first channel
				busy_reg <= 1'b0;
				from_reg <= 4'h0;
			end else if (conv_go) begin
				busy_reg <= 1'b1;
				chan_reg <= go_chan;
				// id bits go out at once, data lands mid-byte
				if (cmd_start) cchan_reg <= go_chan;
				from_reg <= go_chan + 4'h1;
				cyc_reg  <= cmd_start ? 13'(adc_seq_pkg::CMD_CYC)
					: 13'(adc_seq_pkg::AUTO_CYC);
			end else if (done) begin
				busy_reg  <= 1'b0;
				res_reg   <= SAMPLE_DATA;
				cchan_reg <= chan_reg;
				if (chan_reg == adc_seq_pkg::TEMP_ID)
					temp_reg <= SAMPLE_DATA;
			end else if (busy_reg) begin
				cyc_reg <= cyc_reg - 13'h0001;
			end
		end
	end

	// limit status: a new violation wins over a clearing write
	always_comb begin
		alst_next = wr_alert ? 9'h000 : alst_reg;
		if (done && auto_en && viol)
			alst_next[chan_reg] = 1'b1;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			alst_reg <= 9'h000;
		else
			alst_reg <= alst_next;
	end

	// alert pin level follows the polarity bit
	assign LINK.alert = pol ? (|alst_reg) : ~(|alst_reg);
	assign SAMPLE_CHAN = chan_reg;
	assign SAMPLE_REQ  = req_reg;
	assign CONV_BUSY   = busy_reg;
	assign PART_PD     = pd_reg & ~busy_reg;
	assign AUTO_ON     = auto_en;
endmodule : adc_seq_dev

/* hw/adc_seq_host.sv */
// bus controller end: two-wire master commanded over the system bus
// assumes a single AHB-Lite master; the slave never inserts waits
`timescale 1ns/1ps
module adc_seq_host (
	adc_link_if.host          LINK,
	input  wire logic         SYS_CLK,
	input  wire logic         RST_N,
	input  wire logic         HSEL,
	input  wire logic [31:0]  HADDR,
	input  wire logic [1:0]   HTRANS,
	input  wire logic         HWRITE,
	input  wire logic [2:0]   HSIZE,
	input  wire logic [31:0]  HWDATA,
	input  wire logic         HREADY,
	output logic              HREADYOUT,
	output logic [31:0]       HRDATA,
	output logic              HRESP
);
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BYTE  = 2'b10,
		H_STOP  = 2'b11
	} hs_t;

	hs_t         st_reg;
	logic [9:0]  q_reg;
	logic [1:0]  ph_reg, idx_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  tx_reg, rx_reg, ptr_reg;
	logic [15:0] dat_reg, rd_reg;
	adc_seq_pkg::op_t op_reg;
	logic        last_reg, inrd_reg, nack_reg, scl_reg, sda_reg;
	logic        wp_reg;
	logic [7:0]  wa_reg;
	logic [31:0] hr_reg;
	logic [1:0]  sda_sy, al_sy;

	// bus slave: zero wait, always okay
	wire addr_ph = HSEL & HREADY & HTRANS[1];
	wire go = wp_reg & (wa_reg == adc_seq_pkg::H_CTRL) & (st_reg == H_IDLE);
	wire [31:0] rmux =
		(HADDR[7:0] == adc_seq_pkg::H_STAT) ?
			{28'h0, inrd_reg, al_sy[1], nack_reg, st_reg != H_IDLE} :
		(HADDR[7:0] == adc_seq_pkg::H_RDATA) ? {16'h0, rd_reg} : 32'h0;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign HRDATA    = hr_reg;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wp_reg <= 1'b0;
			wa_reg <= 8'h00;
			hr_reg <= 32'h0;
		end else begin
			wp_reg <= addr_ph & HWRITE;
			wa_reg <= HADDR[7:0];
			if (addr_ph && !HWRITE) hr_reg <= rmux;
		end
	end

	// quarter-bit tick from the system clock
	wire tick = q_reg == 10'(adc_seq_pkg::QTR_CYC - 1);
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			q_reg  <= 10'h000;
			sda_sy <= 2'h3;
			al_sy  <= 2'h0;
		end else begin
			q_reg  <= tick ? 10'h000 : q_reg + 10'h001;
			sda_sy <= {sda_sy[0], LINK.sda};
			al_sy  <= {al_sy[0], LINK.alert};
		end
	end

	// byte sequencing within one operation
	wire is_rx   = (op_reg == adc_seq_pkg::OP_READ) & (idx_reg != 2'h0);
	wire [1:0] last_idx = (op_reg == adc_seq_pkg::OP_WRITE) ? 2'h3 :
		(op_reg == adc_seq_pkg::OP_PTR) ? 2'h1 : 2'h2;
	wire [1:0] nidx = idx_reg + 2'h1;
	wire [7:0] nbyte = (nidx == 2'h1) ? ptr_reg :
		(nidx == 2'h2) ? dat_reg[15:8] : dat_reg[7:0];
	// the final read byte is refused only when the last flag is set, so the slave lets go
	wire ack_lvl = ~(last_reg & (idx_reg == 2'h2));
	wire bit_lvl = (bit_reg == 4'h8) ? (is_rx ? ~ack_lvl : 1'b1)
		: (is_rx ? 1'b1 : tx_reg[3'(4'h7 - bit_reg)]);
	wire addr_byte_nack = nack_reg & ~is_rx;

	assign LINK.scl_h_o  = 1'b0;
	assign LINK.scl_h_oe = ~scl_reg;
	assign LINK.sda_h_o  = 1'b0;
	assign LINK.sda_h_oe = ~sda_reg;

	// master line sequencer, four quarters per bit
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg   <= H_IDLE;
			ph_reg   <= 2'h0;
			idx_reg  <= 2'h0;
			bit_reg  <= 4'h0;
			tx_reg   <= 8'h00;
			rx_reg   <= 8'h00;
			ptr_reg  <= 8'h00;
			dat_reg  <= 16'h0000;
			rd_reg   <= 16'h0000;
			op_reg   <= adc_seq_pkg::OP_WRITE;
			last_reg <= 1'b0;
			inrd_reg <= 1'b0;
			nack_reg <= 1'b0;
			scl_reg  <= 1'b1;
			sda_reg  <= 1'b1;
		end else if (go) begin
			op_reg   <= adc_seq_pkg::op_t'(HWDATA[1:0]);
			last_reg <= HWDATA[2];
			ptr_reg  <= HWDATA[15:8];
			dat_reg  <= HWDATA[31:16];
			nack_reg <= 1'b0;
			ph_reg   <= 2'h0;
			bit_reg  <= 4'h0;
			// an open read continues without a new start
			if (inrd_reg && HWDATA[1:0] == 2'b10) begin
				st_reg  <= H_BYTE;
				idx_reg <= 2'h1;
			end else begin
				st_reg   <= H_START;
				inrd_reg <= 1'b0;
			end
		end else if (tick && st_reg != H_IDLE) begin
			ph_reg <= ph_reg + 2'h1;
			unique case (st_reg)
				H_START: unique case (ph_reg)
					2'h0: begin
						scl_reg <= 1'b0;
						sda_reg <= 1'b1;
					end
					2'h1: scl_reg <= 1'b1;
					2'h2: sda_reg <= 1'b0;
					2'h3: begin
						scl_reg <= 1'b0;
						st_reg  <= H_BYTE;
						idx_reg <= 2'h0;
						tx_reg  <= {adc_seq_pkg::SLAVE_ADDR,
							op_reg == adc_seq_pkg::OP_READ};
					end
				endcase
				H_BYTE: unique case (ph_reg)
					2'h0: sda_reg <= bit_lvl;
					2'h1: scl_reg <= 1'b1;
					2'h2: if (bit_reg != 4'h8) begin
						if (is_rx) rx_reg <= {rx_reg[6:0], sda_sy[1]};
					end else if (!is_rx) begin
						nack_reg <= sda_sy[1];
					end
					2'h3: begin
						scl_reg <= 1'b0;
						bit_reg <= (bit_reg == 4'h8) ? 4'h0
							: bit_reg + 4'h1;
						if (bit_reg == 4'h8) begin
							if (idx_reg == 2'h1 && is_rx)
								rd_reg[15:8] <= rx_reg;
							if (idx_reg == 2'h2) rd_reg[7:0] <= rx_reg;
							if (addr_byte_nack) begin
								st_reg <= H_STOP;
							end else if (idx_reg != last_idx) begin
								idx_reg <= nidx;
								tx_reg  <= nbyte;
							end else if (is_rx && !last_reg) begin
								st_reg   <= H_IDLE;
								inrd_reg <= 1'b1;
							end else begin
								st_reg <= H_STOP;
							end
						end
					end
				endcase
				H_STOP: unique case (ph_reg)
					2'h0: begin
						scl_reg <= 1'b0;
						sda_reg <= 1'b0;
					end
					2'h1: scl_reg <= 1'b1;
					2'h2: sda_reg <= 1'b1;
					2'h3: st_reg <= H_IDLE;
				endcase
				default: st_reg <= H_IDLE;
			endcase
		end
	end
endmodule : adc_seq_host

/* dv/adc_seq_checker.sv */
// link and sequencer status checks for the converter pair
// assumes one clock domain; placed beside the link instance
`timescale 1ns/1ps
module adc_seq_checker #(
	parameter int AUTO_PER_CYC = adc_seq_pkg::AUTO_PER_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic sda_d_oe,
	input wire logic alert,
	input wire logic scl,
	input wire logic sda,
	input wire logic CONV_BUSY,
	input wire logic PART_PD,
	input wire logic AUTO_ON,
	input wire logic SAMPLE_REQ
);
	int blen;
	int gap;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// busy run length and idle gap, too long for a repetition
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			blen <= 0;
			gap <= 0;
		end else begin
			blen <= CONV_BUSY ? blen + 1 : 0;
			gap <= (CONV_BUSY || !AUTO_ON) ? 0 : gap + 1;
		end
	end
	// checks on the device end
	property p_busy_awake; CONV_BUSY |-> !PART_PD; endproperty
	a_busy_awake: assert property (p_busy_awake)
		else $error("power-down while converting");
	property p_addr_wake; sda_d_oe |-> !PART_PD; endproperty
	a_addr_wake: assert property (p_addr_wake)
		else $error("device drives link while powered down");
	property p_req_pulse;
		SAMPLE_REQ |-> CONV_BUSY ##1 !SAMPLE_REQ;
	endproperty
	a_req_pulse: assert property (p_req_pulse)
		else $error("sample request not a pulse inside busy");
	property p_cmd_len;
		$fell(CONV_BUSY) && !AUTO_ON |-> blen == adc_seq_pkg::CMD_CYC;
	endproperty
	a_cmd_len: assert property (p_cmd_len)
		else $error("command conversion length wrong");
	property p_stop_pd;
		scl && $rose(sda) && !AUTO_ON && !CONV_BUSY |-> ##[1:8] PART_PD;
	endproperty
	a_stop_pd: assert property (p_stop_pd)
		else $error("no power-down after stop");
	property p_sda_hold; scl && $past(scl) |-> $stable(sda_d_oe);
	endproperty
	a_sda_hold: assert property (p_sda_hold)
		else $error("device data moved while clock high");
	property p_auto_gap; AUTO_ON |-> gap <= AUTO_PER_CYC; endproperty
	a_auto_gap: assert property (p_auto_gap)
		else $error("autocycle conversion overdue");
	property p_auto_len;
		$fell(CONV_BUSY) && AUTO_ON |-> blen == adc_seq_pkg::AUTO_CYC;
	endproperty
	a_auto_len: assert property (p_auto_len)
		else $error("autocycle conversion length wrong");
	property p_auto_awake; AUTO_ON |-> !PART_PD; endproperty
	a_auto_awake: assert property (p_auto_awake)
		else $error("power-down during autocycle");
	c_cmd: cover property ($fell(CONV_BUSY) && !AUTO_ON);
	c_auto: cover property ($fell(CONV_BUSY) && AUTO_ON);
	c_alert: cover property ($changed(alert));
	c_stop: cover property (scl && $rose(sda));
endmodule : adc_seq_checker

/* dv/tb.sv */
// bench: controller and converter joined by the link, bus driven here
// assumes a 250 MHz clock; link ops are slow, so scenarios are few
`timescale 1ns/1ps
module tb;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic [11:0] samp;
	logic [3:0]  samp_chan;
	logic        samp_req;
	logic        conv_busy;
	logic        part_pd;
	logic        auto_on;
	logic [11:0] smp [0:8];
	logic [15:0] rnd;
	logic [26:0] mon;
	logic        scl_q;
	logic [31:0] d;
	logic [15:0] w;
	int          bad_count;
	int          compares;
	adc_link_if link();
	adc_seq_host adc_seq_host_i(.LINK(link), .SYS_CLK(clk), .RST_N(rst_n),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP());
	adc_seq_dev #(.AUTO_PER_CYC(2000), .LIMIT_HIGH(12'h800)) adc_seq_dev_i(
		.LINK(link), .SYS_CLK(clk), .RST_N(rst_n), .SAMPLE_DATA(samp),
		.SAMPLE_CHAN(samp_chan), .SAMPLE_REQ(samp_req),
		.CONV_BUSY(conv_busy), .PART_PD(part_pd), .AUTO_ON(auto_on));
	adc_seq_checker #(.AUTO_PER_CYC(2000)) adc_seq_checker_i(
		.SYS_CLK(clk), .RST_N(rst_n), .sda_d_oe(link.sda_d_oe),
		.alert(link.alert), .scl(link.scl), .sda(link.sda),
		.CONV_BUSY(conv_busy), .PART_PD(part_pd), .AUTO_ON(auto_on),
		.SAMPLE_REQ(samp_req));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	// result word: channel id above the sample
	function automatic logic [15:0] word(input logic [3:0] ch);
		return {ch, smp[ch]};
	endfunction : word
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one single word transfer; waits on hready, no fixed latency
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// start a link op, then poll busy; a hang is cut by the watchdog
	task automatic op(input logic [31:0] ctrl);
		ahb(1'b1, 32'(adc_seq_pkg::H_CTRL), ctrl, d);
		do ahb(1'b0, 32'(adc_seq_pkg::H_STAT), 32'h0, d);
		while (d[0] !== 1'b0);
		ahb(1'b0, 32'(adc_seq_pkg::H_RDATA), 32'h0, d);
	endtask : op
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// sample source follows the channel under conversion
	always @(posedge clk) begin
		samp <= smp[samp_chan];
		scl_q <= link.scl;
		if (link.scl && !scl_q)
			mon <= {mon[25:0], link.sda};
	end
	// link traffic needs about 103k cycles; the margin stays small
	initial begin
		repeat (110000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		{bad_count, compares} = '0;
		rst_n = 1'b0;
		rnd = 16'h0004;
		for (int i = 0; i < 9; i++) begin
			rnd = lfsr(rnd);
			smp[i] = rnd[11:0];
		end
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check(32'(auto_on), 32'h0);
		check(32'(part_pd), 32'h1);
		check(32'(link.alert), 32'h1);
		check(32'({link.scl, link.sda}), 32'h3);
		// status: idle, no nack, alert pin inactive high
		ahb(1'b0, 32'(adc_seq_pkg::H_STAT), 32'h0, d);
		check(d, 32'h4);
		$display("test reset done");
		// channels 0 and 2, then pointer to the voltage result
		op(32'hA000_0000);
		op(32'h0000_0101);
		check(32'(part_pd), 32'h1);
		op(32'h0000_0002);
		w = word(4'h0);
		check(32'(d[15:0]), 32'(w));
		check(32'(mon), 32'({adc_seq_pkg::SLAVE_ADDR, 2'b10, w[15:8],
			1'b0, w[7:0], 1'b0}));
		op(32'h0000_0002);
		check(32'(d[15:0]), 32'(word(4'h2)));
		op(32'h0000_0006);
		check(32'(d[15:0]), 32'(word(4'h0)));
		repeat (12) @(posedge clk);
		check(32'(part_pd), 32'h1);
		$display("test command done");
		// autocycle above the high limit, alert active high
		for (int i = 0; i < 9; i++)
			smp[i] = 12'hFFF;
		op(32'hA009_0000);
		check(32'(auto_on), 32'h1);
		for (int i = 0; i < 3000 && conv_busy !== 1'b1; i++)
			@(posedge clk);
		check(32'(samp_chan), 32'h0);
		for (int i = 0; i < 3000 && conv_busy !== 1'b0; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		check(32'(link.alert), 32'h1);
		check(32'(part_pd), 32'h0);
		ahb(1'b0, 32'(adc_seq_pkg::H_STAT), 32'h0, d);
		check(32'(d[2]), 32'h1);
		$display("test autocycle done");
		conclude();
	end
endmodule : tb
